/* design/pst_pkg.sv */
// Package for the periodic tick timer: register map, fields, reset values
// and the bus request carrier.
// Assumes a 32-bit word bus with byte addresses and aligned word accesses.
package pst_pkg;

  // ********************
  // Register map
  // ********************
  localparam logic [31:0] ADDR_CONTROL = 32'hE000E010;
  localparam logic [31:0] ADDR_START = 32'hE000E014;
  localparam logic [31:0] ADDR_NOW = 32'hE000E018;
  localparam logic [31:0] ADDR_REF_INFO = 32'hE000E01C;
  localparam logic [31:0] ADDR_EVT_STATUS = 32'hE000E020;
  localparam logic [31:0] ADDR_EVT_MASK = 32'hE000E024;

  // ********************
  // Fields
  // ********************
  localparam int CNT_W = 24;
  localparam int BIT_ENABLE = 0;
  localparam int BIT_IRQ_ENABLE = 1;
  localparam int BIT_CLOCK_SELECT = 2;
  localparam int BIT_ZERO_FLAG = 16;
  localparam int BIT_EXT_REF_ABSENT = 31;
  localparam int BIT_TICK_REF_INFO_INEXACT = 30;
  localparam int BIT_EVT_WRAP = 0;

  // ********************
  // Reset and fixed values
  // ********************
  localparam logic [31:0] RST_CONTROL = 32'h00000004;
  localparam logic [23:0] RST_START = 24'h000000;
  localparam logic [23:0] RST_NOW = 24'h000000;
  localparam logic [23:0] TICK_REF_INFO_TICKS = 24'h002904;
  localparam logic EXT_REF_ABSENT = 1'b0;
  localparam logic TICK_REF_INFO_INEXACT = 1'b0;

  // ********************
  // Timing
  // ********************
  localparam int PRESCALE_DIV = 8;
  localparam int PRESCALE_W = 3;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pst_bus_req_s;

endpackage : pst_pkg

/* design/pst_timer.sv */
// Periodic tick timer: 24-bit down counter with reload, flag, request
// and an event status/mask pair driving one level interrupt.
// Assumes bus master, halt and sleep inputs all run on mclk.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pst_timer
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register bus
  input wire pst_pkg::pst_bus_req_s bus,
  output logic [31:0] rdata,
  // Core status
  input wire logic dbg_halt,
  input wire logic core_sleep,
  // Requests
  output logic tick_req,
  output logic irq
);

  // ********************
  // Decode
  // ********************
  logic wr_ctrl, wr_start, wr_now, rd_ctrl, wr_status, wr_mask;
  assign wr_ctrl = bus.wr && (bus.addr == pst_pkg::ADDR_CONTROL);
  assign wr_start = bus.wr && (bus.addr == pst_pkg::ADDR_START);
  assign wr_now = bus.wr && (bus.addr == pst_pkg::ADDR_NOW);
  assign wr_status = bus.wr && (bus.addr == pst_pkg::ADDR_EVT_STATUS);
  assign wr_mask = bus.wr && (bus.addr == pst_pkg::ADDR_EVT_MASK);
  assign rd_ctrl = bus.rd && (bus.addr == pst_pkg::ADDR_CONTROL);

  // ********************
  // Control register
  // ********************
  logic enable, irq_enable, clock_select;
  logic start_now;

  // Only a rising enable loads; rewriting one while running keeps the count
  assign start_now = wr_ctrl && bus.wdata[pst_pkg::BIT_ENABLE] && !enable;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      enable <= pst_pkg::RST_CONTROL[pst_pkg::BIT_ENABLE];
      irq_enable <= pst_pkg::RST_CONTROL[pst_pkg::BIT_IRQ_ENABLE];
      clock_select <= pst_pkg::RST_CONTROL[pst_pkg::BIT_CLOCK_SELECT];
    end
    else if (wr_ctrl)
    begin
      enable <= bus.wdata[pst_pkg::BIT_ENABLE];
      irq_enable <= bus.wdata[pst_pkg::BIT_IRQ_ENABLE];
      clock_select <= bus.wdata[pst_pkg::BIT_CLOCK_SELECT];
    end
  end

  logic [pst_pkg::CNT_W-1:0] start_value;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      start_value <= pst_pkg::RST_START;
    else if (wr_start)
      start_value <= bus.wdata[pst_pkg::CNT_W-1:0];
  end

  // ********************
  // Prescaler
  // ********************
  logic [pst_pkg::PRESCALE_W-1:0] prescale;
  logic running, tick;

  // Gated core clock and debug halt both freeze prescaler and counter
  assign running = enable && !dbg_halt && !core_sleep;
  assign tick = running && (clock_select || (prescale == '1));

  always_ff @(posedge mclk)
  begin
    if (!resetn || start_now)
      prescale <= '0;
    else if (running)
      prescale <= prescale + 1'b1;
  end

  // ********************
  // Down counter
  // ********************
  logic [pst_pkg::CNT_W-1:0] count;
  logic wrap;

  // Only the one-to-zero step counts as a wrap, so a zero reload stays quiet
  assign wrap = tick && (count == 24'h000001);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      count <= pst_pkg::RST_NOW;
    else if (wr_now)
      count <= '0;
    else if (start_now)
      count <= start_value;
    else if (tick)
    begin
      if (count == '0)
        count <= start_value;
      else
        count <= count - 1'b1;
    end
  end

  // ********************
  // Zero flag and request
  // ********************
  logic zero_flag;

  // Set wins over read-clear and over the clear from a value write
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      zero_flag <= 1'b0;
    else if (wrap)
      zero_flag <= 1'b1;
    else if (rd_ctrl || wr_now)
      zero_flag <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      tick_req <= 1'b0;
    else
      tick_req <= wrap && irq_enable;
  end

  // ********************
  // Event status, mask, interrupt
  // ********************
  logic evt_wrap, mask_wrap;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      evt_wrap <= 1'b0;
    else if (wrap)
      evt_wrap <= 1'b1;
    else if (wr_status && bus.wdata[pst_pkg::BIT_EVT_WRAP])
      evt_wrap <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mask_wrap <= 1'b0;
    else if (wr_mask)
      mask_wrap <= bus.wdata[pst_pkg::BIT_EVT_WRAP];
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= evt_wrap && mask_wrap;
  end

  // ********************
  // Read data
  // ********************
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (bus.rd)
    begin
      unique case (bus.addr)
        pst_pkg::ADDR_CONTROL:
        begin
          next_rdata[pst_pkg::BIT_ENABLE] = enable;
          next_rdata[pst_pkg::BIT_IRQ_ENABLE] = irq_enable;
          next_rdata[pst_pkg::BIT_CLOCK_SELECT] = clock_select;
          next_rdata[pst_pkg::BIT_ZERO_FLAG] = zero_flag;
        end
        pst_pkg::ADDR_START:
          next_rdata[pst_pkg::CNT_W-1:0] = start_value;
        pst_pkg::ADDR_NOW:
          next_rdata[pst_pkg::CNT_W-1:0] = count;
        pst_pkg::ADDR_REF_INFO:
        begin
          next_rdata[pst_pkg::CNT_W-1:0] = pst_pkg::TICK_REF_INFO_TICKS;
          next_rdata[pst_pkg::BIT_EXT_REF_ABSENT] = pst_pkg::EXT_REF_ABSENT;
          next_rdata[pst_pkg::BIT_TICK_REF_INFO_INEXACT] = pst_pkg::TICK_REF_INFO_INEXACT;
        end
        pst_pkg::ADDR_EVT_STATUS:
          next_rdata[pst_pkg::BIT_EVT_WRAP] = evt_wrap;
        pst_pkg::ADDR_EVT_MASK:
          next_rdata[pst_pkg::BIT_EVT_WRAP] = mask_wrap;
        default:
          next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata <= 32'h00000000;
    else
      rdata <= next_rdata;
  end

  // ********************
  // Assertions
  // ********************
  a_wrap_reload: assert property (@(posedge mclk) disable iff (!resetn)
    (tick && count == '0 && !wr_now && !start_now) |=> count == $past(start_value))
    else $error("counter did not reload after zero");

  a_halt_hold: assert property (@(posedge mclk) disable iff (!resetn)
    ((dbg_halt || core_sleep) && !wr_now && !start_now) |=> $stable(count))
    else $error("counter moved while halted or asleep");

  a_flag_read_clear: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_ctrl && zero_flag && !wrap) |=> !zero_flag && rdata[pst_pkg::BIT_ZERO_FLAG])
    else $error("flag read did not return one then clear");

  a_div8_spacing: assert property (@(posedge mclk) disable iff (!resetn)
    (tick && !clock_select && !wr_ctrl) |=> (!tick || clock_select) [*7])
    else $error("divided tick came sooner than eight cycles");

  a_req_gated: assert property (@(posedge mclk) disable iff (!resetn)
    (count == 24'h000001 && running && clock_select && !wr_ctrl && !wr_now)
      |=> tick_req == $past(irq_enable))
    else $error("tick request does not follow interrupt enable");

  a_enable_load: assert property (@(posedge mclk) disable iff (!resetn)
    (start_now && !wr_now) |=> count == $past(start_value) && enable)
    else $error("enable did not load the reload value");

  a_wrap_flag: assert property (@(posedge mclk) disable iff (!resetn)
    wrap |=> zero_flag && evt_wrap ##1 irq == mask_wrap)
    else $error("wrap did not raise flag and event");

  a_zero_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    (count == '0 && start_value == '0 && !zero_flag && !rd_ctrl && !wr_now
      && !start_now) |=> !zero_flag && !tick_req)
    else $error("zero reload produced a flag or request");

  a_now_write: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_now && !wrap) |=> count == '0 && !zero_flag)
    else $error("value write did not zero count and flag");

  a_tick_ref_info_read: assert property (@(posedge mclk) disable iff (!resetn)
    (bus.rd && bus.addr == pst_pkg::ADDR_REF_INFO)
      |=> rdata == {8'h00, pst_pkg::TICK_REF_INFO_TICKS})
    else $error("calibration read wrong");

  a_start_keeps: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_start && !tick && !wr_now && !start_now) |=> $stable(count))
    else $error("reload write disturbed the count");

  a_stop_hold: assert property (@(posedge mclk) disable iff (!resetn)
    (!enable && !wr_now && !wr_ctrl) |=> $stable(count))
    else $error("counter moved while disabled");

  // A wrap leaves the count at zero, so a second request cannot follow at once
  a_req_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    tick_req |=> !tick_req)
    else $error("tick request longer than one cycle");

  a_irq_masked: assert property (@(posedge mclk) disable iff (!resetn)
    !mask_wrap |=> !irq)
    else $error("interrupt raised while masked");

  a_status_sticky: assert property (@(posedge mclk) disable iff (!resetn)
    (evt_wrap && !(wr_status && bus.wdata[pst_pkg::BIT_EVT_WRAP])) |=> evt_wrap)
    else $error("event status lost without a clear");

endmodule : pst_timer

`default_nettype wire

/* test/test_pst_timer.sv */
// Self-checking bench for the periodic tick timer.
// Assumes pst_timer and pst_pkg compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_pst_timer;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  pst_pkg::pst_bus_req_s bus = '0;
  logic [31:0] rdata;
  logic dbg_halt = 1'b0;
  logic core_sleep = 1'b0;
  logic tick_req;
  logic irq;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h68B7;
  logic [31:0] v;
  logic [31:0] w;
  logic [23:0] r;
  logic sel;
  int n;

  always #12.5 mclk = ~mclk;

  pst_timer DUT
  (
    .mclk(mclk),
    .resetn(resetn),
    .bus(bus),
    .rdata(rdata),
    .dbg_halt(dbg_halt),
    .core_sleep(core_sleep),
    .tick_req(tick_req),
    .irq(irq)
  );

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] exp_gap(input logic [23:0] rl, input logic s, input logic first);
    // First pulse after enable is one count shorter than a full period
    return 32'((s ? 1 : 8) * (int'(rl) + (first ? 0 : 1)));
  endfunction : exp_gap

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_tick(output int c);
    c = 0;
    do
    begin
      @(posedge mclk);
      #1 c++;
    end
    while (tick_req !== 1'b1 && c < 400);
  endtask : wait_tick

  task automatic count_ticks(output int k);
    k = 0;
    repeat (60)
    begin
      @(posedge mclk);
      #1 if (tick_req === 1'b1) k++;
    end
  endtask : count_ticks

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Hang guard, well above the thousand or so cycles the tests need
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      final_report;
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd(pst_pkg::ADDR_CONTROL, v);
    check("control reset", v, 32'h00000004);
    rd(pst_pkg::ADDR_START, v);
    check("start reset", v, 32'h00000000);
    rd(pst_pkg::ADDR_NOW, v);
    check("now reset", v, 32'h00000000);
    wr(pst_pkg::ADDR_REF_INFO, 32'hFFFFFFFF);
    rd(pst_pkg::ADDR_REF_INFO, v);
    check("tick_ref_info", v, 32'h00002904);
    rd(pst_pkg::ADDR_EVT_MASK, v);
    check("mask reset", v, 32'h00000000);
    rd(32'hE000E028, v);
    check("unmapped", v, 32'h00000000);
    $display("test registers done");

    for (int i = 0; i < 6; i++)
    begin
      r = (i < 2) ? 24'h000001 : 24'(($random(seed) & 15) + 1);
      sel = i[0];
      wr(pst_pkg::ADDR_CONTROL, 32'h00000004);
      wr(pst_pkg::ADDR_START, {8'h00, r});
      wr(pst_pkg::ADDR_CONTROL, {29'h0, sel, 2'b11});
      wait_tick(n);
      check("first tick", 32'(n), exp_gap(r, sel, 1'b1));
      wait_tick(n);
      check("period", 32'(n), exp_gap(r, sel, 1'b0));
    end
    $display("test periods done");

    wr(pst_pkg::ADDR_CONTROL, 32'h00000004);
    wr(pst_pkg::ADDR_START, 32'h00000014);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000007);
    wait_tick(n);
    rd(pst_pkg::ADDR_CONTROL, v);
    check("flag set", v, 32'h00010007);
    rd(pst_pkg::ADDR_CONTROL, v);
    check("flag cleared", v, 32'h00000007);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000006);
    #1 check("irq masked", 32'(irq), 32'h0);
    rd(pst_pkg::ADDR_EVT_STATUS, v);
    check("status", v, 32'h00000001);
    wr(pst_pkg::ADDR_EVT_MASK, 32'h00000001);
    @(posedge mclk);
    #1 check("irq raised", 32'(irq), 32'h1);
    wr(pst_pkg::ADDR_EVT_STATUS, 32'h00000001);
    @(posedge mclk);
    #1 check("irq cleared", 32'(irq), 32'h0);
    // Counting without request enable still sets the flag
    rd(pst_pkg::ADDR_CONTROL, v);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000005);
    count_ticks(n);
    check("no request", 32'(n), 32'h0);
    rd(pst_pkg::ADDR_CONTROL, v);
    check("flag no irq", v, 32'h00010005);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000004);
    rd(pst_pkg::ADDR_CONTROL, v);
    wr(pst_pkg::ADDR_START, 32'h00000000);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000007);
    count_ticks(n);
    check("zero reload", 32'(n), 32'h0);
    rd(pst_pkg::ADDR_CONTROL, v);
    check("zero reload flag", v, 32'h00000007);
    $display("test flag and irq done");

    wr(pst_pkg::ADDR_CONTROL, 32'h00000004);
    wr(pst_pkg::ADDR_START, 32'h000003E8);
    wr(pst_pkg::ADDR_CONTROL, 32'h00000007);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      dbg_halt <= (k == 0);
      core_sleep <= (k == 1);
      rd(pst_pkg::ADDR_NOW, v);
      wr(pst_pkg::ADDR_START, 32'h00000005);
      repeat (10) @(posedge mclk);
      rd(pst_pkg::ADDR_NOW, w);
      check("frozen", w, v);
      @(posedge mclk);
      dbg_halt <= 1'b0;
      core_sleep <= 1'b0;
      rd(pst_pkg::ADDR_NOW, w);
      check("resumed", 32'(w < v), 32'h1);
    end
    wr(pst_pkg::ADDR_START, 32'h00000014);
    // Zeroing the count makes the new reload take effect at once
    wr(pst_pkg::ADDR_NOW, 32'h00000000);
    wait_tick(n);
    check("reload after clear", 32'(n), exp_gap(24'h000014, 1'b1, 1'b0));
    @(posedge mclk);
    dbg_halt <= 1'b1;
    wr(pst_pkg::ADDR_NOW, 32'h12345678);
    rd(pst_pkg::ADDR_NOW, v);
    check("now zeroed", v, 32'h00000000);
    rd(pst_pkg::ADDR_CONTROL, v);
    check("write clears flag", v, 32'h00000007);
    $display("test freeze and current done");
    final_report;
  end
endmodule : test_pst_timer

`default_nettype wire
